// [hasb_cfg.svh]
`ifndef HASB_CFG_SVH
`define HASB_CFG_SVH

// Word offset of the handler control and state register on the bus.
`define HASB_OFS_CTRL_STATE   4'h0
// Word offset of the write-event status register.
`define HASB_OFS_STATUS       4'h1

`define HASB_BIT_MEM_ACT      0
`define HASB_BIT_BUS_ACT      1
`define HASB_BIT_USG_ACT      3
`define HASB_BIT_SVC_ACT      7
`define HASB_BIT_DBG_ACT      8
`define HASB_BIT_DSR_ACT      10

// Writable positions; bits 9, 6:4 and 2 are reserved.
`define HASB_WRITABLE_MASK    11'h58B
`define HASB_RESET_ACTIVE     11'h000

`endif

// [hasb_pkg.sv]
`default_nettype none

package hasb_pkg;

  typedef logic [10:0] hasb_active_type;

  typedef enum logic [1:0] {
    HASB_IDLE = 2'b00,
    HASB_ANS  = 2'b01
  } hasb_bus_state_type;

endpackage

`default_nettype wire

// [hasb_upd_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Carries an exception-logic or software update into the state store.
interface hasb_upd_if;
  logic                     hw_set_en;
  hasb_pkg::hasb_active_type hw_set;
  hasb_pkg::hasb_active_type hw_clr;
  logic                     sw_wr;
  hasb_pkg::hasb_active_type sw_data;
  hasb_pkg::hasb_active_type active;

  modport store (
    input  hw_set_en,
    input  hw_set,
    input  hw_clr,
    input  sw_wr,
    input  sw_data,
    output active
  );
  modport ctrl (
    output hw_set_en,
    output hw_set,
    output hw_clr,
    output sw_wr,
    output sw_data,
    input  active
  );
endinterface

`default_nettype wire

// [hasb_active_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hasb_cfg.svh"

module hasb_active_store (
  input  wire logic    core_clk_i,
  input  wire logic    rst_n_i,
  hasb_upd_if.store    upd
);

  // Software wins over the exception logic in the same cycle so the
  // register always settles to the value software wrote.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd.active <= `HASB_RESET_ACTIVE;
    end else if (upd.sw_wr) begin
      upd.active <= upd.sw_data & `HASB_WRITABLE_MASK;
    end else if (upd.hw_set_en) begin
      upd.active <= ((upd.active & ~upd.hw_clr) | upd.hw_set)
                    & `HASB_WRITABLE_MASK;
    end
  end

endmodule

`default_nettype wire

// [hasb_top.sv]
// Functional notes
// - Bit 10 shows deferred service active, writable
// - Bit 8 holds debug monitor active, writable
// - Bit 7 shows supervisor call active, writable
// - Bit 3 shows usage fault active, writable
// - Bit 1 shows bus fault active, writable
// - Bit 0 shows memory fault active, writable
// - Bits 9, 6:4, 2 read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "hasb_cfg.svh"

module hasb_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Exception logic of the core.
  input  wire logic        exc_upd_i,
  input  wire logic [10:0] exc_set_i,
  input  wire logic [10:0] exc_clr_i,
  output logic             deferred_service_active_o,
  output logic             debug_monitor_active_o,
  output logic             supervisor_call_active_o,
  output logic             usage_fault_active_o,
  output logic             bus_fault_active_o,
  output logic             memory_management_fault_active_o
);

  // ------------------------------------------------------------
  // State store
  // ------------------------------------------------------------
  hasb_upd_if upd ();

  hasb_active_store u_store (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .upd        (upd)
  );

  hasb_pkg::hasb_bus_state_type state;
  logic                         take;
  logic                         hit_ctrl;
  logic                         hit_stat;
  logic                         collide;
  logic                         sw_wrote;
  logic [10:0]                  merged;

  // ------------------------------------------------------------
  // Address decode and write merge
  // ------------------------------------------------------------
  function automatic logic [10:0] merge_bytes(input logic [10:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [10:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[10:8] = wd[10:8];
    end
    return res;
  endfunction

  function automatic logic addr_hit(input logic [3:0] adr,
                                    input logic [3:0] ofs);
    return adr == ofs;
  endfunction

  assign hit_ctrl = addr_hit(avs_address, `HASB_OFS_CTRL_STATE);
  assign hit_stat = addr_hit(avs_address, `HASB_OFS_STATUS);
  assign merged   = merge_bytes(upd.active, avs_writedata, avs_byteenable);
  // A request is taken only in the idle cycle; the master still holds it
  // through the answer cycle, which must not count as a second access.
  assign take     = (state == hasb_pkg::HASB_IDLE) && (avs_read || avs_write);

  // ------------------------------------------------------------
  // Store update
  // ------------------------------------------------------------
  // The write is committed at the taking edge, the same edge that opens
  // the answer cycle, so a read that follows back to back already sees it.
  assign upd.sw_wr     = take && avs_write && hit_ctrl;
  // Reserved positions are masked inside the store.
  assign upd.sw_data   = merged;
  assign upd.hw_set_en = exc_upd_i;
  assign upd.hw_set    = exc_set_i;
  assign upd.hw_clr    = exc_clr_i;

  assign collide = upd.sw_wr && exc_upd_i;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= hasb_pkg::HASB_IDLE;
    end else begin
      case (state)
        hasb_pkg::HASB_IDLE: begin
          if (avs_read || avs_write) begin
            state <= hasb_pkg::HASB_ANS;
          end
        end
        hasb_pkg::HASB_ANS: begin
          state <= hasb_pkg::HASB_IDLE;
        end
        default: begin
          state <= hasb_pkg::HASB_IDLE;
        end
      endcase
    end
  end

  // Waitrequest idles high and drops for the single answer cycle.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !take;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_response <= 2'h0;
    end else if (take) begin
      avs_response <= (hit_ctrl || hit_stat) ? 2'h0 : 2'h3;
    end
  end

  // Read data hold after the answer until the next access is taken.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (take) begin
      if (avs_read && hit_ctrl) begin
        avs_readdata <= {21'h00_0000, upd.active};
      end else if (avs_read && hit_stat) begin
        avs_readdata <= {31'h0000_0000, sw_wrote};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Collision status
  // ------------------------------------------------------------
  // Sticky flag: a software write met a core update in the same cycle
  // and the core update was dropped. It is cleared by writing one to
  // bit 0 of the status word; a new collision in that cycle wins.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_wrote <= 1'b0;
    end else if (collide) begin
      sw_wrote <= 1'b1;
    end else if (take && avs_write && hit_stat && avs_byteenable[0]
                 && avs_writedata[0]) begin
      sw_wrote <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Active indications to the core
  // ------------------------------------------------------------
  // Each indication lags the register by one cycle; the registered copy
  // keeps bus decode paths out of the core's timing.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deferred_service_active_o <= 1'b0;
    end else begin
      deferred_service_active_o <= upd.active[`HASB_BIT_DSR_ACT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      debug_monitor_active_o <= 1'b0;
    end else begin
      debug_monitor_active_o <= upd.active[`HASB_BIT_DBG_ACT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supervisor_call_active_o <= 1'b0;
    end else begin
      supervisor_call_active_o <= upd.active[`HASB_BIT_SVC_ACT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      usage_fault_active_o <= 1'b0;
    end else begin
      usage_fault_active_o <= upd.active[`HASB_BIT_USG_ACT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_fault_active_o <= 1'b0;
    end else begin
      bus_fault_active_o <= upd.active[`HASB_BIT_BUS_ACT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      memory_management_fault_active_o <= 1'b0;
    end else begin
      memory_management_fault_active_o
        <= upd.active[`HASB_BIT_MEM_ACT];
    end
  end

endmodule

`default_nettype wire

// [hasb_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module hasb_top_properties (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        exc_upd_i,
  input wire logic [10:0] exc_set_i,
  input wire logic [10:0] exc_clr_i,
  input wire logic        deferred_service_active_o,
  input wire logic        debug_monitor_active_o,
  input wire logic        supervisor_call_active_o,
  input wire logic        usage_fault_active_o,
  input wire logic        bus_fault_active_o,
  input wire logic        memory_management_fault_active_o
);
  // ------------------------------------------------------------
  // Shadow of the store
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [10:0] e;
  logic [10:0] m;

  assign m = {{3{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & 11'h58B;

  // Waitrequest is high exactly while the slave is idle, so a write seen
  // with it high is a taken write; it beats a core update in that cycle.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e <= 11'h000;
    end else if (avs_write && avs_waitrequest && (avs_address == 4'h0)) begin
      e <= (e & ~m) | (avs_writedata[10:0] & m);
    end else if (exc_upd_i) begin
      e <= ((e & ~exc_clr_i) | exc_set_i) & 11'h58B;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_DSR: assert property (
    deferred_service_active_o == $past(e[10]))
    else $error("deferred service bit wrong");
  AST_DBG: assert property (
    debug_monitor_active_o == $past(e[8]))
    else $error("debug monitor bit wrong");
  AST_SVC: assert property (
    supervisor_call_active_o == $past(e[7]))
    else $error("supervisor call bit wrong");
  AST_USG: assert property (
    usage_fault_active_o == $past(e[3]))
    else $error("usage fault bit wrong");
  AST_BUS: assert property (
    bus_fault_active_o == $past(e[1]))
    else $error("bus fault bit wrong");
  AST_MEM: assert property (
    memory_management_fault_active_o == $past(e[0]))
    else $error("memory fault bit wrong");
  AST_RSVD: assert property (
    avs_read && !avs_waitrequest && (avs_address == 4'h0)
    |-> (avs_readdata & 32'hFFFF_FA74) == 32'h0000_0000)
    else $error("reserved bit read as one");
  AST_RDATA: assert property (
    avs_read && !avs_waitrequest && (avs_address == 4'h0)
    |-> avs_readdata[10:0] == $past(e))
    else $error("read data differ from register");
  AST_WAIT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_ANS: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  AST_DECERR: assert property (
    (avs_read || avs_write) && avs_waitrequest && (avs_address > 4'h1)
    |=> avs_response == 2'h3)
    else $error("unmapped access not refused");
endmodule
bind hasb_top hasb_top_properties u_props (.*);
`default_nettype wire

// [hasb_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hasb_core_model (
  input  wire logic   core_clk_i,
  output logic        exc_upd_o,
  output logic [10:0] exc_set_o,
  output logic [10:0] exc_clr_o
);
  initial begin
    exc_upd_o = 1'b0;
    exc_set_o = 11'h000;
    exc_clr_o = 11'h000;
  end
  task automatic pulse(input logic [10:0] s, input logic [10:0] c);
    @(posedge core_clk_i);
    exc_upd_o <= 1'b1;
    exc_set_o <= s;
    exc_clr_o <= c;
    @(posedge core_clk_i);
    exc_upd_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test_hasb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_hasb_top;
  logic clk, rst_n, rd, wr, upd, wq;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdata, r;
  logic [1:0]  resp, rs;
  logic [10:0] sv, cv;
  wire  [5:0]  act;
  int error_cnt = 0;
  int samples_checked = 0;
  hasb_top DUT (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wq),
    .avs_response(resp), .exc_upd_i(upd), .exc_set_i(sv),
    .exc_clr_i(cv), .deferred_service_active_o(act[5]),
    .debug_monitor_active_o(act[4]), .supervisor_call_active_o(act[3]),
    .usage_fault_active_o(act[2]), .bus_fault_active_o(act[1]),
    .memory_management_fault_active_o(act[0]));
  hasb_core_model core (.core_clk_i(clk), .exc_upd_o(upd),
    .exc_set_o(sv), .exc_clr_o(cv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_act(input logic [5:0] exp);
    samples_checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t indications %h expected %h", $time, act, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0) begin
      @(posedge clk);
    end
    r = rdata;
    rs = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic t_bits();
    bus(0, 4'h0, 32'h0);
    check(r, 32'h0);
    for (int i = 0; i < 11; i++) begin
      bus(1, 4'h0, 32'h1 << i);
      bus(0, 4'h0, 32'h0);
      check(r, (32'h1 << i) & 32'h58B);
    end
    bus(1, 4'h0, 32'h7FF);
    check({30'h0, rs}, 32'h0);
    be <= 4'h1;
    bus(1, 4'h0, 32'h0);
    be <= 4'hF;
    bus(0, 4'h0, 32'h0);
    check(r, 32'h500);
    check_act(6'h30);
  endtask
  task automatic t_core();
    core.pulse(11'h7FF, 11'h000);
    bus(0, 4'h0, 32'h0);
    check(r, 32'h58B);
    check_act(6'h3F);
    core.pulse(11'h400, 11'h7FF);
    bus(0, 4'h0, 32'h0);
    check(r, 32'h400);
    check_act(6'h20);
  endtask
  task automatic t_collide();
    fork
      bus(1, 4'h0, 32'h3);
      core.pulse(11'h488, 11'h000);
    join
    bus(0, 4'h0, 32'h0);
    check(r, 32'h3);
    check_act(6'h03);
    bus(0, 4'h1, 32'h0);
    check(r, 32'h1);
    bus(1, 4'h1, 32'h1);
    bus(0, 4'h1, 32'h0);
    check(r, 32'h0);
  endtask
  task automatic t_unmapped();
    bus(1, 4'h5, 32'h7FF);
    check({30'h0, rs}, 32'h3);
    bus(0, 4'h0, 32'h0);
    check(r, 32'h3);
  endtask
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_act(6'h00);
    bus(0, 4'h0, 32'h0);
    check(r, 32'h0);
    check({30'h0, rs}, 32'h0);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {rd, wr, adr, wd, be} = {2'b00, 4'h0, 32'h0, 4'hF};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_bits();
    t_core();
    t_collide();
    t_unmapped();
    t_reset();
    end_of_test();
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
